// ==== rtl/card_sdram_defines.vh ====
`ifndef CARD_SDRAM_DEFINES_VH
`define CARD_SDRAM_DEFINES_VH

// Register and window addresses
`define CARD_TIMING_ADDR 32'hFF80_0100
`define AREA2_MODE_BASE 32'hFF90_0000
`define AREA3_MODE_BASE 32'hFF94_0000
`define MODE_OFFSET_MAX 12'hFFC

// Card timing register fields and reset value
`define CARD_TIMING_RESET 16'h0000
`define SET_A_EXTRA_HI 15
`define SET_A_EXTRA_LO 14
`define SET_B_EXTRA_HI 13
`define SET_B_EXTRA_LO 12
`define SET_A_SETUP_HI 11
`define SET_A_SETUP_LO 9
`define SET_B_SETUP_HI 8
`define SET_B_SETUP_LO 6
`define SET_A_HOLD_HI 5
`define SET_A_HOLD_LO 3
`define SET_B_HOLD_HI 2
`define SET_B_HOLD_LO 0

// Extra low-speed card waits
`define EXTRA_WAITS_0 6'h00
`define EXTRA_WAITS_1 6'h0F
`define EXTRA_WAITS_2 6'h1E
`define EXTRA_WAITS_3 6'h32

// Mode value shape on the memory address lines
`define MODE_BITS_64 10
`define MEM_ADDR_W 14

// Timing: clock rate and gap after a mode register set
`define CLK_MHZ 50
`define T_MRD_NS 40

`endif

// ==== rtl/hold_wait_decode.v ====
// Eight-step wait code to wait count: 0,1,2,3,6,9,12,15
module hold_wait_decode (
  input wire [2:0] code_in,
  output reg [3:0] waits_out
);

  // Upper half steps by three to reach fifteen
  always @* begin
    case (code_in)
      3'h0: waits_out = 4'h0;
      3'h1: waits_out = 4'h1;
      3'h2: waits_out = 4'h2;
      3'h3: waits_out = 4'h3;
      3'h4: waits_out = 4'h6;
      3'h5: waits_out = 4'h9;
      3'h6: waits_out = 4'hC;
      default: waits_out = 4'hF;
    endcase
  end

endmodule // hold_wait_decode

// ==== rtl/card_sdram_ctrl.v ====
`include "card_sdram_defines.vh"

module card_sdram_ctrl (
  input wire clk_in,
  input wire sys_rst_in,
  input wire manual_rst_in,
  input wire req_in,
  input wire wr_in,
  input wire [31:0] addr_in,
  input wire [15:0] wdata_in,
  input wire card_access_type_select,
  input wire card_mem_read_in,
  input wire bus_64_in,
  output reg ack_out,
  output reg busy_out,
  output reg [15:0] rdata_out,
  output reg [3:0] setup_waits_out,
  output reg [3:0] hold_waits_out,
  output reg [5:0] extra_waits_out,
  output reg hold_from_sample_out,
  output reg [15:0] sdram_mode_setting_out,
  output reg sdram_cs2_n_out,
  output reg sdram_cs3_n_out,
  output reg sdram_ras_n_out,
  output reg sdram_cas_n_out,
  output reg sdram_we_n_out,
  output reg [13:0] sdram_addr_out
);

  // Command gap after a mode set, rounded up to whole cycles
  localparam integer MRD_CYC_RAW = (`T_MRD_NS * `CLK_MHZ + 999) / 1000;
  localparam integer MRD_CYC = (MRD_CYC_RAW < 1) ? 1 : MRD_CYC_RAW;
  localparam [1:0] MRD_LAST = MRD_CYC[1:0] - 2'h1;
  // Window bases as 32-bit words so their page bits can be sliced
  localparam [31:0] AREA2_BASE = `AREA2_MODE_BASE;
  localparam [31:0] AREA3_BASE = `AREA3_MODE_BASE;

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_MRS = 2'h1;
  localparam [1:0] ST_GAP = 2'h2;

  reg [15:0] card_strobe_timing_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] gap_cnt_q;
  reg [1:0] gap_cnt_d;
  reg area3_q;
  reg area3_d;
  reg [13:0] mode_addr_q;
  reg [13:0] mode_addr_d;

  wire take;
  wire hit_timing;
  wire hit_area2;
  wire hit_area3;
  wire [13:0] mode_addr_32;
  wire [13:0] mode_addr_64;
  wire [3:0] a_setup;
  wire [3:0] b_setup;
  wire [3:0] a_hold;
  wire [3:0] b_hold;
  reg [5:0] extra_d;

  // Taken only while idle; a request still standing at its ack edge is not retaken
  assign take = req_in && !ack_out && (state_q == ST_IDLE);
  assign hit_timing = (addr_in == `CARD_TIMING_ADDR);
  // Window decode on the upper twenty bits; offset bits are the value
  assign hit_area2 = (addr_in[31:12] == AREA2_BASE[31:12]);
  assign hit_area3 = (addr_in[31:12] == AREA3_BASE[31:12]);

  // Memory A0 sits on device A2 (32-bit) or A3 (64-bit)
  assign mode_addr_32 = addr_in[15:2];
  assign mode_addr_64 = {4'h0, addr_in[3 +: `MODE_BITS_64]};

  // Wait decoders, one per setup and hold field
  hold_wait_decode u_a_setup (
    .code_in(card_strobe_timing_q[`SET_A_SETUP_HI:`SET_A_SETUP_LO]),
    .waits_out(a_setup)
  );

  hold_wait_decode u_b_setup (
    .code_in(card_strobe_timing_q[`SET_B_SETUP_HI:`SET_B_SETUP_LO]),
    .waits_out(b_setup)
  );

  hold_wait_decode u_a_hold (
    .code_in(card_strobe_timing_q[`SET_A_HOLD_HI:`SET_A_HOLD_LO]),
    .waits_out(a_hold)
  );

  hold_wait_decode u_b_hold (
    .code_in(card_strobe_timing_q[`SET_B_HOLD_HI:`SET_B_HOLD_LO]),
    .waits_out(b_hold)
  );

  // Card timing register; manual reset deliberately leaves it alone
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      card_strobe_timing_q <= `CARD_TIMING_RESET;
    end else if (take && wr_in && hit_timing) begin
      card_strobe_timing_q <= wdata_in;
    end
  end

  // Extra low-speed waits for the selected set
  always @* begin
    case (card_access_type_select ?
          card_strobe_timing_q[`SET_B_EXTRA_HI:`SET_B_EXTRA_LO] :
          card_strobe_timing_q[`SET_A_EXTRA_HI:`SET_A_EXTRA_LO])
      2'h0: extra_d = `EXTRA_WAITS_0;
      2'h1: extra_d = `EXTRA_WAITS_1;
      2'h2: extra_d = `EXTRA_WAITS_2;
      default: extra_d = `EXTRA_WAITS_3;
    endcase
  end

  // Timing outputs follow the type bit one cycle later
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      setup_waits_out <= 4'h0;
      hold_waits_out <= 4'h0;
      extra_waits_out <= 6'h00;
      hold_from_sample_out <= 1'b0;
    end else begin
      setup_waits_out <= card_access_type_select ? b_setup : a_setup;
      if (card_access_type_select) begin
        hold_waits_out <= b_hold;
      end else begin
        hold_waits_out <= a_hold;
      end
      extra_waits_out <= extra_d;
      // Set B memory reads count hold from the sampling point
      hold_from_sample_out <= card_access_type_select && card_mem_read_in;
    end
  end

  // Mode set sequencer: idle, one command cycle, then the gap
  always @* begin
    state_d = state_q;
    gap_cnt_d = gap_cnt_q;
    area3_d = area3_q;
    mode_addr_d = mode_addr_q;
    case (state_q)
      ST_IDLE: begin
        // Store data is never looked at, only its address
        if (take && wr_in && (hit_area2 || hit_area3)) begin
          state_d = ST_MRS;
          area3_d = hit_area3;
          mode_addr_d = bus_64_in ? mode_addr_64 : mode_addr_32;
        end
      end
      ST_MRS: begin
        state_d = ST_GAP;
        gap_cnt_d = 2'h0;
      end
      ST_GAP: begin
        if (gap_cnt_q >= MRD_LAST) begin
          state_d = ST_IDLE;
        end else begin
          gap_cnt_d = gap_cnt_q + 2'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state; manual reset aborts a pending command
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      gap_cnt_q <= 2'h0;
      area3_q <= 1'b0;
      mode_addr_q <= 14'h0000;
    end else if (manual_rst_in) begin
      state_q <= ST_IDLE;
      gap_cnt_q <= 2'h0;
      area3_q <= 1'b0;
      mode_addr_q <= 14'h0000;
    end else begin
      state_q <= state_d;
      gap_cnt_q <= gap_cnt_d;
      area3_q <= area3_d;
      mode_addr_q <= mode_addr_d;
    end
  end

  // Memory command pins: mode register set is all strobes low
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sdram_cs2_n_out <= 1'b1;
      sdram_cs3_n_out <= 1'b1;
      sdram_ras_n_out <= 1'b1;
      sdram_cas_n_out <= 1'b1;
      sdram_we_n_out <= 1'b1;
      sdram_addr_out <= 14'h0000;
    end else if (manual_rst_in) begin
      sdram_cs2_n_out <= 1'b1;
      sdram_cs3_n_out <= 1'b1;
      sdram_ras_n_out <= 1'b1;
      sdram_cas_n_out <= 1'b1;
      sdram_we_n_out <= 1'b1;
    end else if (state_d == ST_MRS) begin
      sdram_cs2_n_out <= area3_d;
      sdram_cs3_n_out <= ~area3_d;
      sdram_ras_n_out <= 1'b0;
      sdram_cas_n_out <= 1'b0;
      sdram_we_n_out <= 1'b0;
      sdram_addr_out <= mode_addr_d;
    end else begin
      sdram_cs2_n_out <= 1'b1;
      sdram_cs3_n_out <= 1'b1;
      sdram_ras_n_out <= 1'b1;
      sdram_cas_n_out <= 1'b1;
      sdram_we_n_out <= 1'b1;
    end
  end

  // Last mode setting, low sixteen address bits kept for observation
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sdram_mode_setting_out <= 16'h0000;
    end else if (take && wr_in && (hit_area2 || hit_area3)) begin
      sdram_mode_setting_out <= addr_in[15:0];
    end
  end

  // Answer one cycle after a taken request; window reads return zero
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_out <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      ack_out <= take;
      if (take && !wr_in && hit_timing) begin
        rdata_out <= card_strobe_timing_q;
      end else if (take) begin
        rdata_out <= 16'h0000; // Mode setting is write-only
      end
    end
  end

  // Busy while the command and its gap run, so the master holds off
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
    end else if (manual_rst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state_d != ST_IDLE);
    end
  end

endmodule // card_sdram_ctrl

// ==== test/card_sdram_properties.sv ====
module card_sdram_properties (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic manual_rst_in,
  input wire logic req_in,
  input wire logic wr_in,
  input wire logic [31:0] addr_in,
  input wire logic card_access_type_select,
  input wire logic card_mem_read_in,
  input wire logic bus_64_in,
  input wire logic ack_out,
  input wire logic busy_out,
  input wire logic [3:0] hold_waits_out,
  input wire logic hold_from_sample_out,
  input wire logic [15:0] sdram_mode_setting_out,
  input wire logic sdram_cs2_n_out,
  input wire logic sdram_cs3_n_out,
  input wire logic sdram_ras_n_out,
  input wire logic sdram_cas_n_out,
  input wire logic sdram_we_n_out,
  input wire logic [13:0] sdram_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  // Manual reset aborts the sequencer, so it also quiets the checks
  default disable iff (sys_rst_in || manual_rst_in);
  logic [31:0] addr_q;
  // Address of the taken edge, seen one cycle later
  always_ff @(posedge clk_in) addr_q <= addr_in;
  // Stores taken into each mode window
  sequence take2;
    req_in && wr_in && !ack_out && !busy_out && addr_in[31:12] == 20'hFF900;
  endsequence
  sequence take3;
    req_in && wr_in && !ack_out && !busy_out && addr_in[31:12] == 20'hFF940;
  endsequence
  sequence busy_gap;
    busy_out[*3] ##1 !busy_out;
  endsequence
  a_area2_select: assert property (take2 |=> !sdram_cs2_n_out && sdram_cs3_n_out)
    else $error("area 2 store missed its chip select");
  a_area3_select: assert property (take3 |=> !sdram_cs3_n_out && sdram_cs2_n_out)
    else $error("area 3 store missed its chip select");
  a_mode_strobes: assert property (!sdram_ras_n_out |->
    !sdram_cas_n_out && !sdram_we_n_out && ack_out && busy_out)
    else $error("mode command strobes incomplete");
  a_cmd_single: assert property (!sdram_ras_n_out |=> sdram_ras_n_out)
    else $error("mode command longer than one cycle");
  a_busy_gap: assert property ($rose(busy_out) |-> busy_gap)
    else $error("busy not three cycles");
  a_busy_refuse: assert property (busy_out |=> !ack_out)
    else $error("request taken while busy");
  a_value_narrow: assert property ((take2 or take3) ##0 !bus_64_in |=>
    sdram_addr_out == addr_q[15:2] && sdram_mode_setting_out == addr_q[15:0])
    else $error("mode value wrong on 32-bit bus");
  a_value_wide: assert property ((take2 or take3) ##0 bus_64_in |=>
    sdram_addr_out == {4'h0, addr_q[12:3]})
    else $error("mode value wrong on 64-bit bus");
  a_hold_sample: assert property (1'b1 |=>
    hold_from_sample_out == $past(card_access_type_select && card_mem_read_in))
    else $error("hold not counted from sampling");
  a_ack_single: assert property (ack_out |=> !ack_out)
    else $error("one request answered twice");
  a_hold_codes: assert property (hold_waits_out inside
    {4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h9, 4'hC, 4'hF})
    else $error("hold count outside the eight steps");
endmodule // card_sdram_properties

// ==== test/sdram_mode_model.sv ====
module sdram_mode_model (
  input wire logic clk_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [13:0] addr_in,
  output logic [13:0] mode_out,
  output logic legal_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode is latched from the address lines; data lines unused
  always @(posedge clk_in) begin
    if (!cs_n_in && !ras_n_in && !cas_n_in && !we_n_in) begin
      mode_out <= addr_in;
    end
  end
  // Reserved burst, wrap or latency codes leave the chip undefined
  assign legal_out = mode_out[2:1] == 2'h1 && !mode_out[3]
    && mode_out[6:4] inside {3'h1, 3'h2, 3'h3};
endmodule // sdram_mode_model

// ==== test/tb_top.sv ====
`include "card_sdram_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, sys_rst_in = 1, manual_rst_in = 0, req_in = 0, wr_in = 0;
  logic [31:0] addr_in = 32'h0;
  logic [15:0] wdata_in = 16'h0;
  logic card_access_type_select = 0, card_mem_read_in = 0, bus_64_in = 0;
  logic ack_out, busy_out, hold_from_sample_out, ok2, ok3;
  logic sdram_cs2_n_out, sdram_cs3_n_out, sdram_ras_n_out, sdram_cas_n_out, sdram_we_n_out;
  logic [15:0] rdata_out, sdram_mode_setting_out, rd;
  logic [3:0] setup_waits_out, hold_waits_out;
  logic [5:0] extra_waits_out;
  logic [13:0] sdram_addr_out, mode2, mode3;
  logic [3:0] w [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h9, 4'hC, 4'hF};
  logic [5:0] e [4] = '{6'h00, 6'h0F, 6'h1E, 6'h32};
  int bad_count = 0, n_tests = 0;
  localparam logic [31:0] TREG = `CARD_TIMING_ADDR;
  always #10 clk_in = ~clk_in;
  card_sdram_ctrl u_dut (.*);
  // One memory model per area, sharing the command strobes
  sdram_mode_model u_sd2 (.clk_in(clk_in), .cs_n_in(sdram_cs2_n_out),
    .ras_n_in(sdram_ras_n_out), .cas_n_in(sdram_cas_n_out), .we_n_in(sdram_we_n_out),
    .addr_in(sdram_addr_out), .mode_out(mode2), .legal_out(ok2));
  sdram_mode_model u_sd3 (.clk_in(clk_in), .cs_n_in(sdram_cs3_n_out),
    .ras_n_in(sdram_ras_n_out), .cas_n_in(sdram_cas_n_out), .we_n_in(sdram_we_n_out),
    .addr_in(sdram_addr_out), .mode_out(mode3), .legal_out(ok3));
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Request stands until ack is sampled high at a rising edge; data taken there
  task bus(input logic wr, input logic [31:0] a, input logic [15:0] d);
    int i;
    bit seen;
    seen = 0;
    @(negedge clk_in);
    req_in = 1;
    wr_in = wr;
    addr_in = a;
    wdata_in = d;
    for (i = 0; i < 20 && !seen; i++) begin
      @(posedge clk_in);
      seen = (ack_out === 1'b1);
      rd = rdata_out;
    end
    if (!seen) begin
      check(16'h0, 16'h1);
      end_sim;
    end
    @(negedge clk_in);
    req_in = 0;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in) sys_rst_in = 0;
    bus(0, TREG, 16'h0);
    check(rd, 16'h0000);
    bus(1, TREG, 16'hA5C3);
    bus(0, TREG, 16'h0);
    check(rd, 16'hA5C3);
    // Every code in each set, the two sets holding different codes
    for (int c = 0; c < 8; c++) begin
      bus(1, TREG, {2'(c), 2'(c + 2), 3'(7 - c), 3'(c), 3'(c), 3'(7 - c)});
      card_access_type_select = 0;
      cyc(2);
      check(hold_waits_out, w[c]);
      check(setup_waits_out, w[7 - c]);
      check(extra_waits_out, e[c % 4]);
      card_access_type_select = 1;
      cyc(2);
      check(hold_waits_out, w[7 - c]);
      check(setup_waits_out, w[c]);
      check(extra_waits_out, e[(c + 2) % 4]);
    end
    card_mem_read_in = 1;
    cyc(2);
    check(hold_from_sample_out, 16'h1);
    card_access_type_select = 0;
    cyc(2);
    check(hold_from_sample_out, 16'h0);
    // Legal mode values only; second store queued behind the busy gap
    bus(1, `AREA2_MODE_BASE + 32'h0088, 16'hFFFF);
    bus(1, `AREA3_MODE_BASE + 32'h00CC, 16'h1234);
    cyc(1);
    check(mode2, 16'h0022);
    check(mode3, 16'h0033);
    check(sdram_mode_setting_out, 16'h00CC);
    check(ok2 & ok3, 16'h1);
    bus_64_in = 1;
    bus(1, `AREA2_MODE_BASE + 32'h0118, 16'h0);
    cyc(1);
    check(mode2, 16'h0023);
    // Unmapped write dropped; unmapped and mode window read as zero
    bus(1, 32'hFF80_0200, 16'hFFFF);
    bus(0, 32'hFF80_0200, 16'h0);
    check(rd, 16'h0000);
    bus(0, `AREA2_MODE_BASE, 16'h0);
    check(rd, 16'h0000);
    manual_rst_in = 1;
    cyc(1);
    manual_rst_in = 0;
    bus(0, TREG, 16'h0);
    check(rd, 16'hD1F8);
    sys_rst_in = 1;
    cyc(4);
    sys_rst_in = 0;
    bus(0, TREG, 16'h0);
    check(rd, 16'h0000);
    end_sim;
  end
endmodule // tb_top
bind card_sdram_ctrl card_sdram_properties u_props (.*);
